// ### voltage_reference_regs.vh
// Register map constants for the fixed reference control block.
// Assumes inclusion by the APB register bank and its gain decoder.
`ifndef VOLTAGE_REFERENCE_REGS_VH
`define VOLTAGE_REFERENCE_REGS_VH

`define VREF_CTRL_ADDR 12'h000
`define VREF_ADDR_W 12
`define VREF_CTRL_RESET 8'h00
`define VREF_ENABLE_BIT 7
`define VREF_READY_BIT 6
`define VREF_TEMP_EN_BIT 5
`define VREF_TEMP_RANGE_BIT 4
`define VREF_CDAC_GAIN_HI 3
`define VREF_CDAC_GAIN_LO 2
`define VREF_ADC_GAIN_HI 1
`define VREF_ADC_GAIN_LO 0
`define VREF_GAIN_OFF 2'h0
`define VREF_GAIN_1X 2'h1
`define VREF_GAIN_2X 2'h2
`define VREF_GAIN_4X 2'h3

`endif

// ### gain_stage_decode.v
// One programmable reference buffer: decodes a 2-bit gain select.
// Assumes the select comes from a register on the same clock.
`timescale 1ns/1ns
`include "voltage_reference_regs.vh"

module gain_stage_decode (
  input wire clk_in, // Core clock.
  input wire srst_in, // Synchronous reset, active high.
  input wire [1:0] gain_sel_in, // Gain select field.
  output reg buffer_on_out, // Buffer powered.
  output reg [2:0] gain_onehot_out // Bit 0 is 1x, bit 1 is 2x, bit 2 is 4x.
);

  always @(posedge clk_in) begin
    if (srst_in) begin
      buffer_on_out <= 1'b0;
      gain_onehot_out <= 3'h0;
    end else begin
      buffer_on_out <= (gain_sel_in != `VREF_GAIN_OFF);
      case (gain_sel_in)
        `VREF_GAIN_1X: gain_onehot_out <= 3'h1;
        `VREF_GAIN_2X: gain_onehot_out <= 3'h2;
        `VREF_GAIN_4X: gain_onehot_out <= 3'h4;
        default: gain_onehot_out <= 3'h0;
      endcase
    end
  end

endmodule // gain_stage_decode

// ### voltage_reference_control.v
// APB register bank for the fixed voltage reference and temperature indicator.
// Assumes a single core clock; outputs are static levels to analog circuitry.
`timescale 1ns/1ns
`include "voltage_reference_regs.vh"

module voltage_reference_control (
  input wire clk_in, // Core clock, 250 MHz.
  input wire srst_in, // Synchronous reset, active high.
  input wire psel, // APB select.
  input wire penable, // APB access phase.
  input wire pwrite, // APB write.
  input wire [11:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  input wire [3:0] pstrb, // APB byte strobes.
  output wire pready, // APB ready, always high.
  output reg [31:0] prdata, // APB read data.
  output wire pslverr, // APB error on unmapped address.
  output reg reference_enable_out, // Reference enabled.
  output wire reference_ready_out, // Reference ready indication.
  output reg temp_indicator_enable_out, // Temperature indicator enabled.
  output reg temp_range_select_out, // One selects high range.
  output wire cdac_buffer_on_out, // Comparator/DAC buffer powered.
  output wire [2:0] cdac_gain_out, // Comparator/DAC gain one-hot.
  output wire adc_buffer_on_out, // ADC buffer powered.
  output wire [2:0] adc_gain_out // ADC gain one-hot.
);

  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  wire addr_hit;
  wire wr_access;
  wire [7:0] ctrl_view;

  assign addr_hit = (paddr == `VREF_CTRL_ADDR);
  assign wr_access = psel && penable && pwrite && addr_hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // The reference is always ready on this device, even before enabling.
  assign reference_ready_out = 1'b1;

  // Ready bit is not stored; it is forced high on read.
  assign ctrl_view = {ctrl_reg[7], 1'b1, ctrl_reg[5:0]};

  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_access && pstrb[0]) begin
      ctrl_next = pwdata[7:0];
    end
    ctrl_next[`VREF_READY_BIT] = 1'b0;
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_reg <= `VREF_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= (paddr == `VREF_CTRL_ADDR) ? {24'h000000, ctrl_view} : 32'h00000000;
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      reference_enable_out <= 1'b0;
      temp_indicator_enable_out <= 1'b0;
      temp_range_select_out <= 1'b0;
    end else begin
      reference_enable_out <= ctrl_reg[`VREF_ENABLE_BIT];
      temp_indicator_enable_out <= ctrl_reg[`VREF_TEMP_EN_BIT];
      temp_range_select_out <= ctrl_reg[`VREF_TEMP_RANGE_BIT];
    end
  end

  // Two separate stages so each path is programmed independently.
  gain_stage_decode cdac_stage (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .gain_sel_in(ctrl_reg[`VREF_CDAC_GAIN_HI:`VREF_CDAC_GAIN_LO]),
    .buffer_on_out(cdac_buffer_on_out),
    .gain_onehot_out(cdac_gain_out)
  );

  gain_stage_decode adc_stage (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .gain_sel_in(ctrl_reg[`VREF_ADC_GAIN_HI:`VREF_ADC_GAIN_LO]),
    .buffer_on_out(adc_buffer_on_out),
    .gain_onehot_out(adc_gain_out)
  );

endmodule // voltage_reference_control

// ### vrc_sva.sv
// Port checker for the reference control bank.
// Bound at the foot of this file; one clock.
`timescale 1ns/1ns
module vrc_sva (input wire clk_in, srst_in, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr, input wire [31:0] pwdata, prdata, input wire [3:0] pstrb,
  input wire reference_enable_out, reference_ready_out, temp_indicator_enable_out,
  input wire temp_range_select_out, cdac_buffer_on_out, adc_buffer_on_out,
  input wire [2:0] cdac_gain_out, adc_gain_out);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire acc = psel && penable;
  wire wr = acc && pwrite && pstrb[0] && !paddr;
  a_ready_high: assert property (reference_ready_out) else $error("rdy");
  a_enable_set: assert property (wr |-> ##2
    reference_enable_out == $past(pwdata[7], 2)) else $error("en");
  a_temp_set: assert property (wr |-> ##2
    {temp_indicator_enable_out, temp_range_select_out} == $past(pwdata[5:4], 2)) else $error("ts");
  a_gain_set: assert property (wr |-> ##2 {cdac_gain_out, adc_gain_out} ==
    {3'h4 >> ~$past(pwdata[3:2], 2), 3'h4 >> ~$past(pwdata[1:0], 2)}) else $error("gn");
  a_buffer_power: assert property (wr |-> ##2
    {cdac_buffer_on_out, adc_buffer_on_out} ==
    {|$past(pwdata[3:2], 2), |$past(pwdata[1:0], 2)}) else $error("bf");
  a_zero_wait: assert property (acc |-> pready) else $error("wt");
  a_error_map: assert property (acc |-> pslverr == (paddr != 12'h000)) else $error("er");
  a_read_image: assert property (acc && !pwrite && !paddr |->
    prdata[6] && prdata[31:8] == 24'h0) else $error("rd");
  a_reset_clear: assert property (disable iff (1'b0) srst_in [*2] |=>
    !reference_enable_out && !cdac_buffer_on_out && !adc_buffer_on_out &&
    {cdac_gain_out, adc_gain_out} == 6'h00) else $error("rs");
  c_write: cover property (wr);
  c_error: cover property (acc && pslverr);
  c_read: cover property (acc && !pwrite);
endmodule // vrc_sva
bind voltage_reference_control vrc_sva i_vrc_sva (.*);

// ### voltage_reference_control_tb.sv
// Bench for the reference control bank.
// Drives APB itself; reads are checked from a queue.
`timescale 1ns/1ns
module voltage_reference_control_tb;
  reg clk_in = 0, srst_in = 1, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] pstrb = 4'h0;
  wire pready, pslverr, reference_enable_out, reference_ready_out, temp_indicator_enable_out,
    temp_range_select_out, cdac_buffer_on_out, adc_buffer_on_out;
  wire [2:0] cdac_gain_out, adc_gain_out;
  wire [31:0] prdata;
  logic [44:0] q[$];
  logic [7:0] c = 8'h00;
  int n_errors = 0, checked = 0, n;
  voltage_reference_control i_voltage_reference_control (.*);
  initial forever #2 clk_in = ~clk_in;
  task end_sim(input int e);
    n_errors += e;
    $display("%0d errors, %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Expected one-hot gain for a select: off, 1x, 2x, 4x.
  function automatic logic [2:0] hot(input logic [1:0] g);
    hot = 3'((4'h1 << g) >> 1);
  endfunction
  task chk(input logic [44:0] s, e);
    checked++;
    if (s !== e) n_errors++;
    if (s !== e) $display("mismatch %0t %h %h", $time, s, e);
  endtask
  always @(posedge clk_in)
    if (psel && penable && pready && !pwrite) chk({reference_enable_out, reference_ready_out,
      temp_indicator_enable_out, temp_range_select_out, cdac_buffer_on_out, cdac_gain_out,
      adc_buffer_on_out, adc_gain_out, pslverr, prdata}, q.pop_front());
  task apb(input logic w, input logic [11:0] a, input logic [7:0] v, input logic [3:0] s);
    @(posedge clk_in);
    if (w && s[0] && !a) c = v & 8'hBF;
    if (!w) q.push_back({c[7], 1'b1, c[5:4], |c[3:2], hot(c[3:2]), |c[1:0], hot(c[1:0]),
      a ? 33'h100000000 : {25'h0, c | 8'h40}});
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, $urandom & 32'hFFFFFF00 | v, s};
    @(posedge clk_in) penable <= 1;
    n = 0;
    do @(posedge clk_in); while (!pready && ++n < 50);
    {psel, penable} <= 2'h0;
    if (!pready) end_sim(1);
  endtask
  initial begin
    void'($urandom(32'hE801));
    repeat (4) @(posedge clk_in);
    srst_in <= 0;
    apb(0, 12'h000, 8'h00, 4'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1, 12'h000, {4'($urandom), i[1:0], ~i[1:0]}, i == 5 ? 4'hE : 4'h1);
      apb(0, 12'h000, 8'h00, 4'h0);
      apb(i[0], 12'h004 << i, 8'hFF, 4'hF);
    end
    srst_in <= 1;
    repeat (2) @(posedge clk_in);
    srst_in <= 0;
    c = 8'h00;
    apb(0, 12'h000, 8'h00, 4'h0);
    end_sim(0);
  end
endmodule // voltage_reference_control_tb
